// *** shared/eth_cfg.svh ***
// register map, field positions and reset values of the event trigger and homing setup block
`ifndef ETH_CFG_SVH
`define ETH_CFG_SVH
// register indices as printed; byte address is four times the index
`define ETH_IDX_RISE_MAP     12'h5C4
`define ETH_IDX_FALL_MAP     12'h5C6
`define ETH_IDX_HOME_SETUP   12'h600
`define ETH_IDX_HOME_COORD   12'h602
`define ETH_IDX_STATUS       12'h604
`define ETH_IDX_CONTROL      12'h605
`define ETH_RST_MAP          16'h0000
`define ETH_RST_SETUP        32'h0000_0000
`define ETH_RST_COORD        32'h0000_0000
`define ETH_CMD_BASE         6'h32
`define ETH_FIELD_MAX        4'hD
`define ETH_PATH_LSB         0
`define ETH_ACC_LSB          8
`define ETH_FIRST_DECEL_INDEX_LSB         12
`define ETH_SECOND_DECEL_INDEX_LSB         16
`define ETH_DLY_LSB          20
`define ETH_BOOT_LSB         28
`define ETH_PATH_MAX         6'h3F
`endif

// *** shared/eth_pkg.sv ***
// types of the event trigger and homing setup block
package eth_pkg;
    typedef enum logic [1:0] {
        ETH_IDLE,
        ETH_HOMING,
        ETH_STOPPING,
        ETH_DONE
    } eth_home_state_t;
endpackage : eth_pkg

// *** rtl/eth_edge_detect.sv ***
// event input edge detector, one pulse per edge
`timescale 1ns/1ps
`include "eth_cfg.svh"
module eth_edge_detect
    import eth_pkg::*;
#(
    parameter int N = 4
) (
    // clock and reset
    input  wire logic         sys_clk,
    input  wire logic         rst_n,
    // event levels and edges
    input  wire logic [N-1:0] level_in,
    output logic      [N-1:0] rise_pulse,
    output logic      [N-1:0] fall_pulse
);
    typedef struct packed {
        logic [N-1:0] prev;
        logic [N-1:0] rise;
        logic [N-1:0] fall;
    } eth_edge_state_t;

    eth_edge_state_t st_q;
    eth_edge_state_t st_d;

    always_comb begin
        st_d      = st_q;
        st_d.prev = level_in;
        st_d.rise = level_in & ~st_q.prev;
        st_d.fall = ~level_in & st_q.prev;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign rise_pulse = st_q.rise;
    assign fall_pulse = st_q.fall;

    single_pulse_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        |rise_pulse |-> ((rise_pulse & $past(rise_pulse)) == '0))
        else $error("rise pulse held two cycles");
endmodule // eth_edge_detect

// *** rtl/eth_launch_arb.sv ***
// picks one pending launch request, lowest input first
`timescale 1ns/1ps
`include "eth_cfg.svh"
module eth_launch_arb
    import eth_pkg::*;
#(
    parameter int N = 8
) (
    // requests
    input  wire logic [N-1:0]   req,
    input  wire logic [N*4-1:0] fields,
    // winner
    output logic                any,
    output logic [$clog2(N)-1:0] idx,
    output logic [3:0]          field
);
    always_comb begin
        any   = 1'b0;
        idx   = '0;
        field = 4'h0;
        for (int i = N - 1; i >= 0; i--) begin
            if (req[i]) begin
                any   = 1'b1;
                idx   = i[$clog2(N)-1:0];
                field = fields[i*4 +: 4];
            end
        end
    end
endmodule // eth_launch_arb

// *** rtl/eth_trigger_home.sv ***
// event trigger dispatch, homing setup registers and APB slave
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`include "eth_cfg.svh"
// Functional notes
// - rise map: four 4-bit fields, input one lowest
// - rise field zero launches nothing
// - rise field 1..D launches command 50+field
// - fall map, same layout, zero launches nothing
// - fall field 1..D launches command 51..63
// - path zero: stop after homing, no path
// - path 1..63 starts after homing
// - acceleration index from bits 11..8
// - first deceleration index from bits 15..12
// - delay index from bits 23..20
// - boot field one runs homing at power-up; here homing starts on the first load of the setup word after reset
// - home detected: decelerate motor to stop
// - signed 32-bit home coordinate sets origin
module eth_trigger_home
    import eth_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [13:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // event inputs
    input  wire logic        event_input_one,
    input  wire logic        event_input_two,
    input  wire logic        event_input_three,
    input  wire logic        event_input_four,
    // command launch
    output logic             cmd_launch,
    output logic [5:0]       cmd_number,
    // homing motion interface
    input  wire logic        home_detected,
    input  wire logic        motor_stopped,
    output logic             homing_run,
    output logic             decel_request,
    output logic             path_start,
    output logic [5:0]       path_number,
    output logic [3:0]       accel_index,
    output logic [3:0]       first_decel_index,
    output logic [3:0]       second_decel_index,
    output logic [3:0]       delay_index,
    output logic [31:0]      home_coordinate_setting
);
    typedef struct packed {
        logic [15:0]     rise_map;
        logic [15:0]     fall_map;
        logic [31:0]     setup;
        logic [31:0]     coord;
        logic [7:0]      pending;
        logic            launch;
        logic [5:0]      cmd;
        eth_home_state_t hstate;
        logic            boot_seen;
        logic            path_go;
        logic [5:0]      path_num;
        logic            drop_seen;
        logic [31:0]     rdata;
    } eth_state_t;

    eth_state_t st_q;
    eth_state_t st_d;

    logic [3:0] ev_lvl;
    logic [3:0] ev_s1_q;
    logic [3:0] ev_s2_q;
    logic [3:0] rise_p;
    logic [3:0] fall_p;
    logic       arb_any;
    logic [2:0] arb_idx;
    logic [3:0] arb_field;
    logic       wr_en;
    logic       rd_en;
    logic [11:0] idx;
    logic       addr_ok;
    logic [7:0] pend_set;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                old[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return old;
    endfunction

    function automatic logic field_live(input logic [3:0] f);
        return (f != 4'h0) && (f <= `ETH_FIELD_MAX);
    endfunction

    assign ev_lvl = {event_input_four, event_input_three, event_input_two, event_input_one};

    // two-stage input synchroniser
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ev_s1_q <= 4'h0;
            ev_s2_q <= 4'h0;
        end else begin
            ev_s1_q <= ev_lvl;
            ev_s2_q <= ev_s1_q;
        end
    end

    eth_edge_detect #(.N(4)) u_edge (
        .sys_clk    (sys_clk),
        .rst_n      (rst_n),
        .level_in   (ev_s2_q),
        .rise_pulse (rise_p),
        .fall_pulse (fall_p)
    );

    // pending slots 0..3 rising, 4..7 falling; fields follow layout
    eth_launch_arb #(.N(8)) u_arb (
        .req    (st_q.pending),
        .fields ({st_q.fall_map, st_q.rise_map}),
        .any    (arb_any),
        .idx    (arb_idx),
        .field  (arb_field)
    );

    assign idx     = paddr[13:2];
    assign wr_en   = psel && penable && pwrite;
    assign rd_en   = psel && !pwrite;
    assign addr_ok = (idx == `ETH_IDX_RISE_MAP) || (idx == `ETH_IDX_FALL_MAP) ||
                     (idx == `ETH_IDX_HOME_SETUP) || (idx == `ETH_IDX_HOME_COORD) ||
                     (idx == `ETH_IDX_STATUS) || (idx == `ETH_IDX_CONTROL);

    always_comb begin
        st_d        = st_q;
        st_d.launch = 1'b0;
        st_d.path_go = 1'b0;
        // only edges whose field is live become requests
        for (int i = 0; i < 4; i++) begin
            pend_set[i]     = rise_p[i] && field_live(st_q.rise_map[i*4 +: 4]);
            pend_set[i + 4] = fall_p[i] && field_live(st_q.fall_map[i*4 +: 4]);
        end
        if (arb_any) begin
            st_d.launch = 1'b1;
            st_d.cmd    = `ETH_CMD_BASE + {2'b00, arb_field};
            st_d.pending[arb_idx] = 1'b0;
        end
        // a new edge wins over the clear of its slot
        st_d.pending = st_d.pending | pend_set;

        if (wr_en) begin
            case (idx)
                `ETH_IDX_RISE_MAP:   st_d.rise_map = 16'(merge({16'h0, st_q.rise_map},
                                                               pwdata, pstrb));
                `ETH_IDX_FALL_MAP:   st_d.fall_map = 16'(merge({16'h0, st_q.fall_map},
                                                               pwdata, pstrb));
                `ETH_IDX_HOME_SETUP: st_d.setup = merge(st_q.setup, pwdata, pstrb);
                `ETH_IDX_HOME_COORD: st_d.coord = merge(st_q.coord, pwdata, pstrb);
                `ETH_IDX_CONTROL: begin
                    if (pstrb[0] && pwdata[0] && st_q.hstate == ETH_IDLE) begin
                        st_d.hstate = ETH_HOMING;
                    end
                end
                default: ;
            endcase
        end

        // homing sequence
        case (st_q.hstate)
            ETH_IDLE: begin
                // boot field acts on the first load of the setup word after reset
                if (!st_q.boot_seen && wr_en && idx == `ETH_IDX_HOME_SETUP) begin
                    st_d.boot_seen = 1'b1;
                    if (st_d.setup[`ETH_BOOT_LSB +: 4] == 4'h1) begin
                        st_d.hstate = ETH_HOMING;
                    end
                end
            end
            ETH_HOMING: begin
                if (home_detected) begin
                    st_d.hstate = ETH_STOPPING;
                end
            end
            ETH_STOPPING: begin
                if (motor_stopped) begin
                    st_d.hstate   = ETH_DONE;
                    st_d.path_num = st_q.setup[`ETH_PATH_LSB +: 6];
                    st_d.path_go  = st_q.setup[`ETH_PATH_LSB +: 6] != 6'h00;
                end
            end
            ETH_DONE: begin
                st_d.hstate = ETH_IDLE;
            end
            default: st_d.hstate = ETH_IDLE;
        endcase

        st_d.rdata = 32'h0000_0000;
        if (rd_en) begin
            case (idx)
                `ETH_IDX_RISE_MAP:   st_d.rdata = {16'h0000, st_q.rise_map};
                `ETH_IDX_FALL_MAP:   st_d.rdata = {16'h0000, st_q.fall_map};
                `ETH_IDX_HOME_SETUP: st_d.rdata = st_q.setup;
                `ETH_IDX_HOME_COORD: st_d.rdata = st_q.coord;
                `ETH_IDX_STATUS:     st_d.rdata = {22'h0, st_q.pending, st_q.hstate};
                default:             st_d.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q          <= '0;
            st_q.rise_map <= `ETH_RST_MAP;
            st_q.fall_map <= `ETH_RST_MAP;
            st_q.setup    <= `ETH_RST_SETUP;
            st_q.coord    <= `ETH_RST_COORD;
            st_q.hstate   <= ETH_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    assign pready             = 1'b1;
    assign pslverr            = psel && penable && !addr_ok;
    assign prdata             = st_q.rdata;
    assign cmd_launch         = st_q.launch;
    assign cmd_number         = st_q.cmd;
    assign homing_run         = st_q.hstate == ETH_HOMING;
    assign decel_request      = st_q.hstate == ETH_STOPPING;
    assign path_start         = st_q.path_go;
    assign path_number        = st_q.path_num;
    assign accel_index        = st_q.setup[`ETH_ACC_LSB +: 4];
    assign first_decel_index  = st_q.setup[`ETH_FIRST_DECEL_INDEX_LSB +: 4];
    assign second_decel_index = st_q.setup[`ETH_SECOND_DECEL_INDEX_LSB +: 4];
    assign delay_index        = st_q.setup[`ETH_DLY_LSB +: 4];
    assign home_coordinate_setting = st_q.coord;

    cmd_range_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        cmd_launch |-> (cmd_number >= 6'd51 && cmd_number <= 6'd63))
        else $error("launched command out of range");
    zero_field_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (rise_p[3] && st_q.rise_map[15:12] == 4'h0 && st_q.pending == 8'h0
         && fall_p == 4'h0 && rise_p[2:0] == 3'h0) |=> !cmd_launch)
        else $error("zero field launched a command");
    rise_launch_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (rise_p[0] && st_q.rise_map[3:0] == 4'h1 && st_q.pending == 8'h0)
        |=> ##1 (cmd_launch && cmd_number == 6'd51))
        else $error("rise field one did not launch command 51");
    fall_launch_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (fall_p[0] && st_q.fall_map[3:0] == 4'hD && st_q.pending == 8'h0 && rise_p == 4'h0)
        |=> ##1 (cmd_launch && cmd_number == 6'd63))
        else $error("fall field D did not launch command 63");
    stop_path_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        path_start |-> path_number != 6'h00)
        else $error("path started with path zero");
    auto_path_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (decel_request && motor_stopped && st_q.setup[5:0] != 6'h00)
        |=> (path_start && path_number == $past(st_q.setup[5:0])))
        else $error("path not started after homing");
    home_decel_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (homing_run && home_detected) |=> decel_request)
        else $error("home detect did not decelerate");
    accel_field_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (wr_en && idx == `ETH_IDX_HOME_SETUP && pstrb[1])
        |=> accel_index == $past(pwdata[11:8]))
        else $error("accel index not from bits 11..8");
    decel_field_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (wr_en && idx == `ETH_IDX_HOME_SETUP && pstrb[1])
        |=> first_decel_index == $past(pwdata[15:12]))
        else $error("decel index not from bits 15..12");
    delay_field_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (wr_en && idx == `ETH_IDX_HOME_SETUP && pstrb[2])
        |=> delay_index == $past(pwdata[23:20]))
        else $error("delay index not from bits 23..20");
    coord_store_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (wr_en && idx == `ETH_IDX_HOME_COORD && pstrb == 4'hF)
        |=> home_coordinate_setting == $past(pwdata))
        else $error("home coordinate not stored");
    boot_home_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (!st_q.boot_seen && st_q.hstate == ETH_IDLE && wr_en && idx == `ETH_IDX_HOME_SETUP
         && pstrb[3] && pwdata[31:28] == 4'h1) |=> homing_run)
        else $error("boot homing not started");

    launch_c: cover property (@(posedge sys_clk) disable iff (!rst_n) cmd_launch);
    two_launch_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
        cmd_launch ##1 cmd_launch);
    path_c: cover property (@(posedge sys_clk) disable iff (!rst_n) path_start);
endmodule // eth_trigger_home

// *** testbench/eth_event_partner.sv ***
// far-side model: event input levels and a motor that homes and stops
`timescale 1ns/1ps
module eth_event_partner (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    // motion side of the block
    input  wire logic       homing_run,
    input  wire logic       decel_request,
    output logic            home_detected,
    output logic            motor_stopped,
    // event lines
    output logic [3:0]      ev
);
    int home_dly = 3;
    int stop_dly = 2;
    int cnt;

    initial ev = 4'h0;

    // level change right after an edge, held until the next call
    task automatic set_ev(input int i, input logic v);
        @(posedge sys_clk);
        ev[i] <= v;
    endtask

    // all four levels at once, right after an edge
    task automatic set_lvl(input logic [3:0] v);
        @(posedge sys_clk);
        ev <= v;
    endtask

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            home_detected <= 1'b0;
            motor_stopped <= 1'b1;
            cnt           <= 0;
        end else if (decel_request === 1'b1) begin
            cnt <= cnt + 1;
            if (cnt >= home_dly + stop_dly)
                motor_stopped <= 1'b1;
        end else if (homing_run === 1'b1) begin
            motor_stopped <= 1'b0;
            cnt           <= cnt + 1;
            if (cnt == home_dly)
                home_detected <= 1'b1;
        end else begin
            cnt           <= 0;
            home_detected <= 1'b0;
        end
    end
endmodule // eth_event_partner

// *** testbench/tb_top.sv ***
// self-checking bench: registers over apb, event launches, homing sequence
`timescale 1ns/1ps
`include "eth_cfg.svh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; \
    $display("BAD %s exp %0h got %0h", nm, e, g); end end
module tb_top;
    import eth_pkg::*;
    logic sys_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [13:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [3:0]  pstrb = 4'h0, ev, ai, d1i, d2i, dli;
    logic        pready, pslverr, err, cmd_launch, home_detected, motor_stopped;
    logic        homing_run, decel_request, path_start;
    logic [5:0]  cmd_number, path_number;
    logic [31:0] home_coordinate_setting;
    logic [5:0]  nums[$];
    int          fails = 0, num_checks = 0, starts = 0, n;

    always #4 sys_clk = ~sys_clk;

    eth_trigger_home i_eth_trigger_home (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .event_input_one(ev[0]),
        .event_input_two(ev[1]), .event_input_three(ev[2]), .event_input_four(ev[3]),
        .cmd_launch(cmd_launch), .cmd_number(cmd_number), .home_detected(home_detected),
        .motor_stopped(motor_stopped), .homing_run(homing_run),
        .decel_request(decel_request), .path_start(path_start), .path_number(path_number),
        .accel_index(ai), .first_decel_index(d1i), .second_decel_index(d2i),
        .delay_index(dli), .home_coordinate_setting(home_coordinate_setting));

    eth_event_partner i_eth_event_partner (.sys_clk(sys_clk), .rst_n(rst_n),
        .homing_run(homing_run), .decel_request(decel_request),
        .home_detected(home_detected), .motor_stopped(motor_stopped), .ev(ev));

    always @(posedge sys_clk) begin
        if (cmd_launch === 1'b1)
            nums.push_back(cmd_number);
        if (path_start === 1'b1) begin
            starts++;
            `CHK("path_number", 6'h05, path_number)
        end
    end

    task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] wd);
        @(posedge sys_clk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= {idx, 2'b00};
        pwdata  <= wd;
        pstrb   <= 4'hF;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic t_reset_values();
        logic [11:0] ix[4] = '{`ETH_IDX_RISE_MAP, `ETH_IDX_FALL_MAP,
                               `ETH_IDX_HOME_SETUP, `ETH_IDX_HOME_COORD};
        foreach (ix[i]) begin
            apb(1'b0, ix[i], '0);
            `CHK("reset_value", 32'h0000_0000, rd)
        end
        apb(1'b1, 12'h100, 32'hFFFF_FFFF);
        `CHK("unmapped_err", 1'b1, err)
        apb(1'b0, 12'h100, '0);
        `CHK("unmapped_read", 32'h0000_0000, rd)
        `CHK("no_boot_homing", 1'b0, homing_run)
    endtask

    // one pin per pass, each field checked against the map written
    task automatic t_edges(input logic fall, input logic [15:0] map);
        logic [3:0] f;
        apb(1'b1, fall ? `ETH_IDX_FALL_MAP : `ETH_IDX_RISE_MAP, {16'h0, map});
        for (int i = 0; i < 4; i++) begin
            f = map[4*i+:4];
            nums.delete();
            i_eth_event_partner.set_ev(i, ~fall);
            repeat (20) @(posedge sys_clk);
            `CHK("launch_count", (f != 0) ? 1 : 0, nums.size())
            if (f != 0 && nums.size() == 1)
                `CHK("launch_num", 6'd50 + 6'(f), nums[0])
        end
    endtask

    task automatic t_back_to_back();
        apb(1'b1, `ETH_IDX_RISE_MAP, 32'h0000_0042);
        apb(1'b1, `ETH_IDX_FALL_MAP, 32'h0000_0000);
        nums.delete();
        i_eth_event_partner.set_lvl(4'b0011);
        repeat (20) @(posedge sys_clk);
        `CHK("pair_count", 2, nums.size())
        if (nums.size() == 2) begin
            `CHK("pair_first", 6'd52, nums[0])
            `CHK("pair_second", 6'd54, nums[1])
        end
        i_eth_event_partner.set_lvl(4'b0000);
        repeat (10) @(posedge sys_clk);
    endtask

    task automatic t_homing(input logic [5:0] path, input int slow);
        int p = -200, s = 300;
        apb(1'b1, `ETH_IDX_HOME_SETUP, {24'h009B_73, 2'b00, path});
        @(posedge sys_clk);
        `CHK("accel_index", 4'h3, ai)
        `CHK("decel2_index", 4'hB, d2i)
        `CHK("decel_index", 4'h7, d1i)
        `CHK("delay_index", 4'h9, dli)
        apb(1'b1, `ETH_IDX_HOME_COORD, 32'(p - s));
        @(posedge sys_clk);
        `CHK("coordinate", 32'hFFFF_FE0C, home_coordinate_setting)
        i_eth_event_partner.stop_dly = slow;
        starts = 0;
        apb(1'b1, `ETH_IDX_CONTROL, 32'h0000_0001);
        n = 0;
        while (decel_request !== 1'b1 && n < 100) begin
            @(posedge sys_clk);
            n++;
        end
        `CHK("decel_on_home", 1'b1, home_detected & decel_request)
        repeat (slow + 30) @(posedge sys_clk);
        `CHK("path_starts", (path != 0) ? 1 : 0, starts)
        `CHK("motor_at_rest", 1'b1, motor_stopped)
    endtask

    // mid-run reset, then a setup load with the boot field set
    task automatic t_boot();
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        apb(1'b0, `ETH_IDX_RISE_MAP, '0);
        `CHK("map_after_reset", 32'h0000_0000, rd)
        starts = 0;
        apb(1'b1, `ETH_IDX_HOME_SETUP, 32'h1000_0005);
        @(posedge sys_clk);
        `CHK("boot_homing", 1'b1, homing_run)
        repeat (40) @(posedge sys_clk);
        `CHK("boot_path", 1, starts)
    endtask

    task automatic results();
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        #(8 * 20000);
        fails++;
        results();
    end

    initial begin
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_reset_values();
        t_edges(1'b0, 16'h0D31);
        t_edges(1'b1, 16'h20CD);
        t_back_to_back();
        t_homing(6'h05, 2);
        t_homing(6'h00, 12);
        t_boot();
        results();
    end
endmodule // tb_top
